// File: include/low_rate_clock_timer_consts.vh
// Register map, field positions and timing constants of the low-rate clock timer.
`ifndef LOW_RATE_CLOCK_TIMER_CONSTS_VH
`define LOW_RATE_CLOCK_TIMER_CONSTS_VH

// Register indices as printed; byte address is four times the index.
`define REG_CONTROL_IDX     16'h5000
`define REG_COUNT_IDX       16'h5001
`define REG_MASK_IDX        16'h5002
`define REG_FLAGS_IDX       16'h5003

// Control register fields.
`define CTL_RUN_BIT         0
`define CTL_CLEAR_BIT       4

// Cause bit positions in mask and flag registers.
`define CAUSE_32HZ          3
`define CAUSE_8HZ           2
`define CAUSE_2HZ           1
`define CAUSE_1HZ           0
`define CAUSE_COUNT         4

// Counter taps that feed each cause.
`define TAP_32HZ            2
`define TAP_8HZ             4
`define TAP_2HZ             6
`define TAP_1HZ             7

// Reset values.
`define COUNT_RESET         8'h00
`define MASK_RESET          4'h0
`define FLAGS_RESET         4'h0

// Tick timing: 256 Hz from a 250 MHz clock.
`define CLOCK_HZ            250000000
`define TICK_HZ             256
`define TICK_DIV            (`CLOCK_HZ / `TICK_HZ)

`endif

// File: rtl/low_rate_clock_timer.v
// Low-rate clock timer: 8-bit tick counter, cause flags and Avalon-MM register slave.
//
// Design decision made here: the Avalon-MM interface to the registers.

`include "low_rate_clock_timer_consts.vh"

module low_rate_clock_timer #(
  parameter TICK_DIV = `TICK_DIV
) (
  // Clock and reset.
  input  wire        clock,
  input  wire        rst,
  // Avalon-MM slave.
  input  wire [17:0] address,
  input  wire        read,
  input  wire        write,
  input  wire [31:0] writedata,
  input  wire [3:0]  byteenable,
  output reg  [31:0] readdata,
  output reg         waitrequest,
  output reg  [1:0]  response,
  // Request to the interrupt controller.
  output reg         irq_request
);

  // Divider state and tick pulse.
  reg  [31:0] div_q;
  reg         tick_q;
  // Timer state.
  reg  [7:0]  count_value_q;
  reg         run_req_q;
  reg         run_active_q;
  reg  [3:0]  mask_q;
  reg  [3:0]  flags_q;
  // Bus acceptance: answer one cycle after the request rises.
  reg         busy_q;

  wire        req      = (read | write) & ~busy_q;
  wire [15:0] reg_idx  = address[17:2];
  wire        addr_ok  = (address[1:0] == 2'h0);
  wire        hit_ctl  = addr_ok & (reg_idx == `REG_CONTROL_IDX);
  wire        hit_cnt  = addr_ok & (reg_idx == `REG_COUNT_IDX);
  wire        hit_msk  = addr_ok & (reg_idx == `REG_MASK_IDX);
  wire        hit_flg  = addr_ok & (reg_idx == `REG_FLAGS_IDX);
  wire        mapped   = hit_ctl | hit_cnt | hit_msk | hit_flg;
  wire        wr_lane0 = req & write & byteenable[0];
  wire        wr_ctl   = wr_lane0 & hit_ctl;
  wire        wr_msk   = wr_lane0 & hit_msk;
  wire        wr_flg   = wr_lane0 & hit_flg;
  wire        clear_cmd = wr_ctl & writedata[`CTL_CLEAR_BIT];

  // Next count and tap edges.
  wire [7:0]  count_next = count_value_q + 8'h01;
  wire        advance    = tick_q & run_active_q;
  wire [3:0]  tap_fall;

  // Divider of the system clock down to a 256 Hz one-cycle tick.
  always @(posedge clock or posedge rst)
  begin
    if (rst)
    begin
      div_q  <= 32'h00000000;
      tick_q <= 1'b0;
    end
    else if (div_q == TICK_DIV - 1)
    begin
      div_q  <= 32'h00000000;
      tick_q <= 1'b1;
    end
    else
    begin
      div_q  <= div_q + 32'h00000001;
      tick_q <= 1'b0;
    end
  end

  // Run request from software, and the run state that follows it at the next tick.
  always @(posedge clock or posedge rst)
  begin
    if (rst)
    begin
      run_req_q    <= 1'b0;
      run_active_q <= 1'b0;
    end
    else
    begin
      if (wr_ctl)
        run_req_q <= writedata[`CTL_RUN_BIT];
      if (tick_q)
        run_active_q <= run_req_q;
    end
  end

  // Counter: clear on command, otherwise advance on each tick while running.
  // A stopped counter is touched only by a clear, so it holds its value or zero.
  always @(posedge clock or posedge rst)
  begin
    if (rst)
      count_value_q <= `COUNT_RESET;
    else if (clear_cmd)
      count_value_q <= `COUNT_RESET;
    else if (advance)
      count_value_q <= count_next;
  end

  // Falling edge of each tap: bit is one now and zero after the advance.
  assign tap_fall[`CAUSE_32HZ] = count_value_q[`TAP_32HZ] & ~count_next[`TAP_32HZ];
  assign tap_fall[`CAUSE_8HZ]  = count_value_q[`TAP_8HZ]  & ~count_next[`TAP_8HZ];
  assign tap_fall[`CAUSE_2HZ]  = count_value_q[`TAP_2HZ]  & ~count_next[`TAP_2HZ];
  assign tap_fall[`CAUSE_1HZ]  = count_value_q[`TAP_1HZ]  & ~count_next[`TAP_1HZ];

  // Mask and cause flags; a new cause wins over a flag write-clear in the same cycle, but a counter clear command suppresses it.
  genvar i;
  generate
    for (i = 0; i < `CAUSE_COUNT; i = i + 1)
    begin : g_cause
      always @(posedge clock or posedge rst)
      begin
        if (rst)
        begin
          mask_q[i]  <= 1'b0;
          flags_q[i] <= 1'b0;
        end
        else
        begin
          if (wr_msk)
            mask_q[i] <= writedata[i];
          if (advance & ~clear_cmd & tap_fall[i])
            flags_q[i] <= 1'b1;
          else if (wr_flg & writedata[i])
            flags_q[i] <= 1'b0;
        end
      end
    end
  endgenerate

  // Shared request line toward the interrupt controller.
  always @(posedge clock or posedge rst)
  begin
    if (rst)
      irq_request <= 1'b0;
    else
      irq_request <= |(flags_q & mask_q);
  end

  // Bus answer: waitrequest drops in the cycle after the request is seen.
  always @(posedge clock or posedge rst)
  begin
    if (rst)
    begin
      busy_q      <= 1'b0;
      waitrequest <= 1'b1;
      readdata    <= 32'h00000000;
      response    <= 2'h0;
    end
    else if (req)
    begin
      busy_q      <= 1'b1;
      waitrequest <= 1'b0;
      response    <= mapped ? 2'h0 : 2'h3;
      readdata    <= 32'h00000000;
      if (read)
      begin
        if (hit_ctl)
          readdata[`CTL_RUN_BIT] <= run_req_q | run_active_q;
        if (hit_cnt)
          readdata[7:0] <= count_value_q;
        if (hit_msk)
          readdata[3:0] <= mask_q;
        if (hit_flg)
          readdata[3:0] <= flags_q;
      end
    end
    else
    begin
      busy_q      <= 1'b0;
      waitrequest <= 1'b1;
    end
  end

endmodule // low_rate_clock_timer

// File: test/low_rate_clock_timer_checker.sv
// Port assertions for the low-rate clock timer, bound to its top module.
module low_rate_clock_timer_checker (
  // Watched ports.
  input wire logic        clock, rst, read, write, waitrequest, irq_request,
  input wire logic [17:0] address,
  input wire logic [31:0] writedata, readdata,
  input wire logic [3:0]  byteenable,
  input wire logic [1:0]  response
);
  timeunit 1ns;
  timeprecision 1ps;
  default clocking cb @(posedge clock);
  endclocking
  default disable iff (rst);
  logic [3:0] mask_q;
  logic       run_q, ran_q;
  wire        wr_ok  = write && !waitrequest && byteenable[0];
  wire        rd_ctl = read && !waitrequest && address == 18'h14000;
  wire        rd_cnt = read && !waitrequest && address == 18'h14004;
  wire        rd_msk = read && !waitrequest && address == 18'h14008;
  wire        rd_flg = read && !waitrequest && address == 18'h1400C;
  // Shadows the mask and the requested run state; ran_q stays set once a start is seen.
  always_ff @(posedge clock or posedge rst)
    if (rst)
      {mask_q, run_q, ran_q} <= 6'h00;
    else if (wr_ok && address == 18'h14008)
      mask_q <= writedata[3:0];
    else if (wr_ok && address == 18'h14000)
      {run_q, ran_q} <= {writedata[0], ran_q | writedata[0]};
  ctl_read_a: assert property (rd_ctl |-> readdata[31:1] == 31'h0)
    else $error("control high bits");
  run_read_a: assert property (rd_ctl && run_q |-> readdata[0])
    else $error("run bit lost");
  stop_default_a: assert property (rd_ctl && !ran_q |-> !readdata[0])
    else $error("run never started");
  count_idle_a: assert property (rd_cnt && !ran_q |-> readdata == 32'h0)
    else $error("count moved");
  count_width_a: assert property (rd_cnt |-> readdata[31:8] == 24'h0)
    else $error("count width");
  mask_back_a: assert property (rd_msk |-> readdata == {28'h0, mask_q})
    else $error("mask readback");
  flag_width_a: assert property (rd_flg |-> readdata[31:4] == 28'h0)
    else $error("flag high bits");
  irq_gate_a: assert property ((mask_q == 4'h0) [*3] |-> !irq_request)
    else $error("request while masked");
  // Main scenarios reached.
  cover property (irq_request);
  cover property (rd_flg && readdata[3:0] == 4'hF);
  cover property (response == 2'b11);
endmodule // low_rate_clock_timer_checker

bind low_rate_clock_timer low_rate_clock_timer_checker i_chk (.clock(clock), .rst(rst),
  .read(read), .write(write), .waitrequest(waitrequest), .irq_request(irq_request),
  .address(address), .writedata(writedata), .readdata(readdata),
  .byteenable(byteenable), .response(response));

// File: test/low_rate_clock_timer_tb.sv
// Register-level testbench for the low-rate clock timer.
module low_rate_clock_timer_tb;
  timeunit 1ns;
  timeprecision 1ps;
  localparam logic [17:0] ctl = 18'h14000, cnt = 18'h14004, msk = 18'h14008, flg = 18'h1400C;
  logic        clock = 1'b0, rst = 1'b1, read = 1'b0, write = 1'b0, waitrequest, irq_request;
  logic [17:0] address = 18'h0;
  logic [31:0] writedata = 32'h0, readdata, rdat;
  logic [3:0]  byteenable = 4'hF;
  logic [1:0]  response, resp;
  int          error_cnt = 0, samples_checked = 0;
  // Clock at 250 MHz.
  always #2 clock = ~clock;
  // Device with an eight-cycle tick.
  low_rate_clock_timer #(.TICK_DIV(8)) i_dut (.clock(clock), .rst(rst), .address(address),
    .read(read), .write(write), .writedata(writedata), .byteenable(byteenable),
    .readdata(readdata), .waitrequest(waitrequest), .response(response),
    .irq_request(irq_request));
  // Prints the counts and the verdict, then ends the run.
  task automatic finish_test();
    $display("checks %0d errors %0d", samples_checked, error_cnt);
    if (error_cnt == 0 && samples_checked > 0)
      $display("TEST PASSED");
    else
      $display("TEST FAILED");
    $finish;
  endtask
  // Compares one value and counts it.
  task automatic chk(input string s, input logic [31:0] e, input logic [31:0] g);
    samples_checked++;
    if (g !== e)
    begin
      error_cnt++;
      $display("[FAIL] %s expected %h seen %h", s, e, g);
    end
  endtask
  // One bus transfer, held until waitrequest is sampled low.
  task automatic acc(input logic w, input logic [17:0] a, input logic [31:0] d);
    int n = 0;
    @(posedge clock);
    read <= !w;
    write <= w;
    address <= a;
    writedata <= d;
    do @(posedge clock); while (waitrequest !== 1'b0 && ++n < 64);
    rdat = readdata;
    resp = response;
    read <= 1'b0;
    write <= 1'b0;
    if (waitrequest !== 1'b0)
    begin
      error_cnt++;
      finish_test();
    end
  endtask
  // Reads a register and compares it.
  task automatic rd(input logic [17:0] a, input logic [31:0] e, input string s);
    acc(1'b0, a, 32'h0);
    chk(s, e, rdat);
  endtask
  // Main sequence.
  initial
  begin
    repeat (16) @(posedge clock);
    rst <= 1'b0;
    rd(ctl, 32'h0, "ctl");
    rd(flg, 32'h0, "flg");
    acc(1'b1, msk, 32'hFF);
    rd(msk, 32'h0F, "msk");
    acc(1'b1, cnt, 32'h55);
    rd(cnt, 32'h0, "cnt");
    acc(1'b0, 18'h14010, 32'h0);
    chk("rsp", 32'h3, {30'h0, resp});
    acc(1'b1, msk, 32'h0);
    acc(1'b1, ctl, 32'h1);
    rd(ctl, 32'h1, "ctl");
    repeat (2100) @(posedge clock);
    acc(1'b1, ctl, 32'h0);
    repeat (20) @(posedge clock);
    rd(ctl, 32'h0, "ctl");
    acc(1'b0, cnt, 32'h0);
    rd(cnt, rdat, "cnt");
    repeat (40) @(posedge clock);
    rd(cnt, rdat, "cnt");
    rd(flg, 32'h0F, "flg");
    acc(1'b1, flg, 32'h05);
    rd(flg, 32'h0A, "flg");
    acc(1'b1, msk, 32'h02);
    repeat (2) @(posedge clock);
    chk("irq", 32'h1, {31'h0, irq_request});
    acc(1'b1, msk, 32'h05);
    repeat (2) @(posedge clock);
    chk("irq", 32'h0, {31'h0, irq_request});
    acc(1'b1, flg, 32'h0F);
    rd(flg, 32'h0, "flg");
    acc(1'b1, ctl, 32'h10);
    rd(cnt, 32'h0, "cnt");
    repeat (40) @(posedge clock);
    rd(cnt, 32'h0, "cnt");
    acc(1'b1, ctl, 32'h11);
    repeat (80) @(posedge clock);
    acc(1'b0, cnt, 32'h0);
    chk("run", 32'h1, {31'h0, rdat > 32'h0 && rdat < 32'h10});
    finish_test();
  end
endmodule // low_rate_clock_timer_tb
